/* File: core/epcal_defs.svh */
// constants of the energy pulse and line cycle calibration block
// assumes inclusion by bare name from the top module, the checker and the bench
`ifndef EPCAL_DEFS_SVH
`define EPCAL_DEFS_SVH

`define EPCAL_ADR_MODE 8'h00
`define EPCAL_ADR_DIV 8'h04
`define EPCAL_ADR_GAIN 8'h08
`define EPCAL_ADR_HALF 8'h0C
`define EPCAL_ADR_STATUS 8'h10
`define EPCAL_ADR_CLEAR 8'h14
`define EPCAL_ADR_ENABLE 8'h18
`define EPCAL_ADR_EN_LO 8'h1C
`define EPCAL_ADR_EN_HI 8'h20
`define EPCAL_ADR_RES_LO 8'h24
`define EPCAL_ADR_RES_HI 8'h28

`define EPCAL_CAL_BIT 7
`define EPCAL_SAG_BIT 0
`define EPCAL_VALID_BIT 31

`define EPCAL_DIV_RESET 12'h03F
`define EPCAL_GAIN_RESET 12'h000
`define EPCAL_HALF_RESET 8'hFF

`define EPCAL_UPD_PHASE 2'h3
`define EPCAL_CLK_MHZ 250
`define EPCAL_PULSE_NS 16
`define EPCAL_PULSE_CYC ((`EPCAL_PULSE_NS * `EPCAL_CLK_MHZ + 999) / 1000)

`endif

/* File: core/epcal_pkg.sv */
// types of the energy pulse and line cycle calibration block
// assumes the defs header sits beside it
package epcal_pkg;
  typedef enum logic [1:0] {CAL_OFF, CAL_WAIT_EDGE, CAL_RUN} epcal_state_e;
  typedef logic [11:0] epcal_word12_t;
endpackage

/* File: core/epcal_top.sv */
// energy to frequency pulse output and zero-cross framed energy calibration
// assumes power words from same-clock logic and a zero-cross level from a pin
`timescale 1ns/1ps
`default_nettype none
`include "epcal_defs.svh"

module epcal_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic signed [23:0] powerLowpassOutput,
  input wire logic zeroCrossOutput,
  output logic pulseFrequencyOutput,
  output logic sagOut_n,
  output logic irqOut_n
);

  // bus state, plus the combinational next status flag
  logic ack_q;
  logic [31:0] rdat_q;
  logic calibrationModeBit_q;
  epcal_pkg::epcal_word12_t frequencyDividerValue_q;
  epcal_pkg::epcal_word12_t powerGainTrim_q;
  logic [7:0] halfCycleCount_q;
  logic sagStatus_q;
  logic sagEnable_q;
  logic sagStatusD;
  // datapath state
  logic [1:0] phase_q;
  logic [23:0] freqAcc_q;
  logic [23:0] freqAccD;
  logic [11:0] divCount_q;
  logic [7:0] pulseCount_q;
  logic pulseOut_q;
  logic signed [39:0] energyAccumulator_q;
  logic signed [39:0] energyResult_q;
  logic resultValid_q;
  logic firstDone_q;
  epcal_pkg::epcal_state_e state_q;
  logic [7:0] halfDone_q;
  logic zxMeta_q;
  logic zxSync_q;
  logic zxLast_q;
  logic sagOutN_q;
  logic irqOutN_q;
  // combinational terms
  logic upd;
  logic zxEdge;
  logic msbRise;
  logic periodEnd;
  logic wbReq;
  logic wbWrite;
  logic signed [11:0] gainS;
  logic signed [35:0] gainProd;
  logic signed [24:0] scaledWord;
  logic signed [39:0] energySum;

  // byte lane merge for a write under sel
  function automatic logic [31:0] wbMerge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[i*8 +: 8] = dat[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // a write lands at the edge where the master sees ack
  assign wbReq = wb_cyc_i & wb_stb_i;
  assign wbWrite = wbReq & wb_we_i & ack_q;

  // registered ack, one wait state, drops the cycle after
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= wbReq & ~ack_q;
    end
  end

  // read mux, unmapped addresses read zero
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rdat_q <= 32'h00000000;
    end
    else if (wbReq & ~ack_q)
    begin
      unique case (wb_adr_i)
        `EPCAL_ADR_MODE: rdat_q <= {24'h000000, calibrationModeBit_q, 7'h00};
        `EPCAL_ADR_DIV: rdat_q <= {20'h00000, frequencyDividerValue_q};
        `EPCAL_ADR_GAIN: rdat_q <= {20'h00000, powerGainTrim_q};
        `EPCAL_ADR_HALF: rdat_q <= {24'h000000, halfCycleCount_q};
        `EPCAL_ADR_STATUS: rdat_q <= {31'h00000000, sagStatus_q};
        `EPCAL_ADR_ENABLE: rdat_q <= {31'h00000000, sagEnable_q};
        `EPCAL_ADR_EN_LO: rdat_q <= energyAccumulator_q[31:0];
        `EPCAL_ADR_EN_HI: rdat_q <= {24'h000000, energyAccumulator_q[39:32]};
        `EPCAL_ADR_RES_LO: rdat_q <= energyResult_q[31:0];
        `EPCAL_ADR_RES_HI: rdat_q <= {resultValid_q, 23'h000000, energyResult_q[39:32]};
        default: rdat_q <= 32'h00000000;
      endcase
    end
  end

  // software control registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      calibrationModeBit_q <= 1'b0;
      frequencyDividerValue_q <= `EPCAL_DIV_RESET;
      powerGainTrim_q <= `EPCAL_GAIN_RESET;
      halfCycleCount_q <= `EPCAL_HALF_RESET;
      sagEnable_q <= 1'b0;
    end
    else if (wbWrite)
    begin
      unique case (wb_adr_i)
        `EPCAL_ADR_MODE: calibrationModeBit_q <= 1'(wbMerge({24'h000000, calibrationModeBit_q, 7'h00},
          wb_dat_i, wb_sel_i) >> `EPCAL_CAL_BIT);
        `EPCAL_ADR_DIV: frequencyDividerValue_q <= 12'(wbMerge({20'h00000, frequencyDividerValue_q}, wb_dat_i,
          wb_sel_i));
        `EPCAL_ADR_GAIN: powerGainTrim_q <= 12'(wbMerge({20'h00000, powerGainTrim_q}, wb_dat_i, wb_sel_i));
        `EPCAL_ADR_HALF: halfCycleCount_q <= 8'(wbMerge({24'h000000, halfCycleCount_q}, wb_dat_i, wb_sel_i));
        `EPCAL_ADR_ENABLE: sagEnable_q <= 1'(wbMerge({31'h00000000, sagEnable_q}, wb_dat_i, wb_sel_i));
        default: ;
      endcase
    end
  end

  // sticky flag, a completion in the clearing cycle wins
  always_comb
  begin
    sagStatusD = sagStatus_q;
    if (wbWrite & (wb_adr_i == `EPCAL_ADR_CLEAR) & wb_sel_i[0] & wb_dat_i[`EPCAL_SAG_BIT])
    begin
      sagStatusD = 1'b0;
    end
    if (periodEnd)
    begin
      sagStatusD = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sagStatus_q <= 1'b0;
    end
    else
    begin
      sagStatus_q <= sagStatusD;
    end
  end

  // open-drain style outputs, low while active, one cycle behind the flag
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      sagOutN_q <= 1'b1;
      irqOutN_q <= 1'b1;
    end
    else
    begin
      sagOutN_q <= ~sagStatus_q;
      irqOutN_q <= ~(sagStatus_q & sagEnable_q);
    end
  end

  // update phase, one word every fourth cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      phase_q <= 2'h0;
    end
    else
    begin
      phase_q <= phase_q + 2'h1;
    end
  end
  assign upd = (phase_q == `EPCAL_UPD_PHASE);

  // gain trim: word + word * trim / 4096, trim signed
  assign gainS = powerGainTrim_q;
  assign gainProd = powerLowpassOutput * gainS;
  assign scaledWord = {powerLowpassOutput[23], powerLowpassOutput} + {gainProd[35], gainProd[35:12]};

  // frequency accumulator wraps mod 2^24; top bit rise every 2^24 of energy
  assign freqAccD = freqAcc_q + scaledWord[23:0];
  assign msbRise = upd & ~freqAcc_q[23] & freqAccD[23];

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      freqAcc_q <= 24'h000000;
    end
    else if (upd)
    begin
      freqAcc_q <= freqAccD;
    end
  end

  // divider: every value+1 top-bit rises give one pulse
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      divCount_q <= 12'h000;
    end
    else if (msbRise)
    begin
      if (divCount_q >= frequencyDividerValue_q)
      begin
        divCount_q <= 12'h000;
      end
      else
      begin
        divCount_q <= divCount_q + 12'h001;
      end
    end
  end

  // fixed-width pulse; top-bit rises are at least 8 cycles apart, so no overlap
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pulseCount_q <= 8'h00;
      pulseOut_q <= 1'b0;
    end
    else if (msbRise & (divCount_q >= frequencyDividerValue_q))
    begin
      pulseCount_q <= 8'(`EPCAL_PULSE_CYC - 1);
      pulseOut_q <= 1'b1;
    end
    else if (pulseCount_q != 8'h00)
    begin
      pulseCount_q <= pulseCount_q - 8'h01;
    end
    else
    begin
      pulseOut_q <= 1'b0;
    end
  end

  // zero-cross pin: two-flop sync, edge detect on the second stage only
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      zxMeta_q <= 1'b0;
      zxSync_q <= 1'b0;
      zxLast_q <= 1'b0;
    end
    else
    begin
      zxMeta_q <= zeroCrossOutput;
      zxSync_q <= zxMeta_q;
      zxLast_q <= zxSync_q;
    end
  end
  assign zxEdge = zxSync_q ^ zxLast_q; // both edges, one per half cycle

  // a count of zero means 256 half cycles through the 8-bit wrap
  assign periodEnd = (state_q == epcal_pkg::CAL_RUN) & zxEdge & ((halfDone_q + 8'h01) == halfCycleCount_q);

  // calibration sequencer
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= epcal_pkg::CAL_OFF;
      halfDone_q <= 8'h00;
    end
    else
    begin
      unique case (state_q)
        epcal_pkg::CAL_OFF:
        begin
          if (calibrationModeBit_q)
          begin
            state_q <= epcal_pkg::CAL_WAIT_EDGE;
          end
        end
        epcal_pkg::CAL_WAIT_EDGE:
        begin
          if (~calibrationModeBit_q)
          begin
            state_q <= epcal_pkg::CAL_OFF;
          end
          else if (zxEdge)
          begin
            state_q <= epcal_pkg::CAL_RUN;
            halfDone_q <= 8'h00;
          end
        end
        epcal_pkg::CAL_RUN:
        begin
          if (~calibrationModeBit_q)
          begin
            state_q <= epcal_pkg::CAL_OFF;
          end
          else if (periodEnd)
          begin
            halfDone_q <= 8'h00;
          end
          else if (zxEdge)
          begin
            halfDone_q <= halfDone_q + 8'h01;
          end
        end
      endcase
    end
  end

  // energy register, signed add with natural 40-bit wrap
  assign energySum = energyAccumulator_q + {{15{scaledWord[24]}}, scaledWord};

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      energyAccumulator_q <= 40'h0000000000;
    end
    else if (((state_q == epcal_pkg::CAL_WAIT_EDGE) & zxEdge & calibrationModeBit_q) | periodEnd)
    begin
      energyAccumulator_q <= 40'h0000000000;
    end
    else if (upd & (state_q != epcal_pkg::CAL_WAIT_EDGE))
    begin
      energyAccumulator_q <= energySum;
    end
  end

  // period result capture; first result after entry is flagged invalid
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      energyResult_q <= 40'h0000000000;
      firstDone_q <= 1'b0;
      resultValid_q <= 1'b0;
    end
    else if (state_q == epcal_pkg::CAL_OFF)
    begin
      firstDone_q <= 1'b0;
      resultValid_q <= 1'b0;
    end
    else if (periodEnd)
    begin
      energyResult_q <= energyAccumulator_q;
      firstDone_q <= 1'b1;
      resultValid_q <= firstDone_q;
    end
  end

  // outputs straight from flops
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign pulseFrequencyOutput = pulseOut_q;
  assign sagOut_n = sagOutN_q;
  assign irqOut_n = irqOutN_q;

endmodule // epcal_top

`default_nettype wire

/* File: verification/epcal_checker.sv */
// assertions on the bus, pulse and calibration outputs
// assumes binding onto epcal_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
`include "epcal_defs.svh"

module epcal_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic signed [23:0] powerLowpassOutput,
  input wire logic zeroCrossOutput,
  input wire logic pulseFrequencyOutput,
  input wire logic sagOut_n,
  input wire logic irqOut_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // status clear taken at the ack edge
  wire clrHit = wb_ack_o && wb_we_i && wb_adr_i == `EPCAL_ADR_CLEAR && wb_sel_i[0] && wb_dat_i[0];
  sequence sReq;
    $rose(wb_cyc_i && wb_stb_i);
  endsequence
  sequence sPulseOn;
    $rose(pulseFrequencyOutput);
  endsequence
  a_ack_follows: assert property (sReq |=> wb_ack_o) else $error("ack missing");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i > `EPCAL_ADR_RES_HI |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_pulse_width: assert property (sPulseOn |-> pulseFrequencyOutput [*4]) else $error("pulse short");
  a_pulse_quiet: assert property ($fell(reset) |-> !pulseFrequencyOutput [*4]) else $error("early pulse");
  a_irq_needs_sag: assert property (!irqOut_n |-> !sagOut_n) else $error("irq without sag");
  a_sag_sticky: assert property (!sagOut_n && !clrHit && !$past(clrHit) |=> !sagOut_n) else $error("sag lost");
  a_sag_release: assert property ($rose(sagOut_n) |-> $past(clrHit, 2)) else $error("sag freed");
endmodule // epcal_checker

bind epcal_top epcal_checker chk_u (.clk(clk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .powerLowpassOutput(powerLowpassOutput), .zeroCrossOutput(zeroCrossOutput),
  .pulseFrequencyOutput(pulseFrequencyOutput), .sagOut_n(sagOut_n), .irqOut_n(irqOut_n));
`default_nettype wire

/* File: verification/epcal_pulse_counter.sv */
// pulse counter in place of the calibration equipment
// assumes the pulse line is synchronous to clk
`timescale 1ns/1ps
`default_nettype none

module epcal_pulse_counter (
  input wire logic clk,
  input wire logic pulse,
  output var int count
);
  logic last = 1'b0;
  initial count = 0;
  // one count per rising edge, width ignored
  always @(posedge clk)
  begin
    if (pulse && !last)
      count <= count + 1;
    last <= pulse;
  end
endmodule // epcal_pulse_counter
`default_nettype wire

/* File: verification/test_energy_pulse_and_line_cycle_cal.sv */
// self-checking bench of the pulse and calibration block
// assumes the checker binds itself from its own file
`timescale 1ns/1ps
`default_nettype none
`include "epcal_defs.svh"

module test_energy_pulse_and_line_cycle_cal;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, zc = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [3:0] sel = 4'h0;
  logic signed [23:0] pw = 24'h000000;
  logic [31:0] rdat, q, d, lo;
  logic ack, pulse, sagN, irqN;
  logic [63:0] note;
  logic [63:0] expQ[$];
  logic [31:0] cfg[4] = '{32'h00000014, 32'h0010000A, 32'h0008000A, 32'h00300005};
  int pulses, n, p;
  int failures = 0;
  int n_checks = 0;
  longint r;

  epcal_top dut_u (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(rdat), .wb_ack_o(ack), .powerLowpassOutput(pw),
    .zeroCrossOutput(zc), .pulseFrequencyOutput(pulse), .sagOut_n(sagN), .irqOut_n(irqN));
  epcal_pulse_counter cnt_u (.clk(clk), .pulse(pulse), .count(pulses));

  // 250 MHz clock
  initial
  begin
    forever #2 clk = ~clk;
  end

  // line half cycle of 64 clocks
  always
  begin
    repeat (64) @(posedge clk);
    zc <= ~zc;
  end

  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // classic cycle held until ack is sampled; the watchdog bounds it
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    sel <= 4'hF;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    expQ.push_back({m, e & m});
    wb(1'b0, a, 32'h0);
  endtask

  task automatic waitSag();
    for (int t = 0; t < 2000 && sagN !== 1'b0; t++)
      @(posedge clk);
    chk("sag", 32'h0, 32'(sagN));
  endtask

  // read answers against the oldest note
  always @(posedge clk)
  begin
    if (ack === 1'b1 && !we && expQ.size() > 0)
    begin
      note = expQ.pop_front();
      chk("read", note[31:0], rdat & note[63:32]);
    end
  end

  initial
  begin
    void'($urandom(25837));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(`EPCAL_ADR_DIV, 32'h3F, 32'hFFF);
    rd(8'h3C, 32'h0, 32'hFFFFFFFF);
    d = $urandom % 4096;
    wb(1'b1, `EPCAL_ADR_DIV, d);
    rd(`EPCAL_ADR_DIV, d, 32'hFFF);
    // one top-bit rise per 32 clocks undivided; table holds divider, gain, pulses per 640
    pw <= 24'h200000;
    foreach (cfg[i])
    begin
      wb(1'b1, `EPCAL_ADR_DIV, 32'(cfg[i][31:20]));
      wb(1'b1, `EPCAL_ADR_GAIN, 32'(cfg[i][19:8]));
      n = pulses;
      repeat (640) @(posedge clk);
      n = pulses - n;
      chk("pulses", 32'h1, 32'(n >= cfg[i][7:0] - 1 && n <= cfg[i][7:0] + 1));
    end
    // negative word over periods of two half cycles, 32 updates each
    p = 1 + $urandom % 4095;
    pw <= 24'(-p);
    wb(1'b1, `EPCAL_ADR_HALF, 32'h2);
    wb(1'b1, `EPCAL_ADR_MODE, 32'h80);
    waitSag();
    chk("irq masked", 32'h1, 32'(irqN));
    rd(`EPCAL_ADR_RES_HI, 32'h0, 32'h80000000);
    rd(`EPCAL_ADR_STATUS, 32'h1, 32'h1);
    wb(1'b1, `EPCAL_ADR_CLEAR, 32'h1);
    @(posedge clk);
    chk("sag cleared", 32'h1, 32'(sagN));
    wb(1'b1, `EPCAL_ADR_ENABLE, 32'h1);
    waitSag();
    chk("irq", 32'h0, 32'(irqN));
    rd(`EPCAL_ADR_RES_LO, 32'h0, 32'h0);
    lo = q;
    rd(`EPCAL_ADR_RES_HI, 32'h80000000, 32'h80000000);
    r = $signed({q[7:0], lo});
    chk("energy", 32'h1, 32'(r <= -31 * p && r >= -33 * p));
    stop_test();
  end

  // hang guard, well past the planned run
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test();
  end
endmodule // test_energy_pulse_and_line_cycle_cal
`default_nettype wire
